// ==== core/sdram_burst_core.sv ====
// command decoder and burst sequencer of a four-bank sdram, memory side
`timescale 1ns/1ps
module sdram_burst_core (
    // clock and reset
    input  wire logic                                  CLK,
    input  wire logic                                  SYS_RST,
    // command bus from the controller
    input  wire logic                                  CKE,
    input  wire logic                                  CS_N,
    input  wire logic                                  RAS_N,
    input  wire logic                                  CAS_N,
    input  wire logic                                  WE_N,
    input  wire logic [sdram_burst_pkg::BA_W-1:0]      BA,
    input  wire logic [sdram_burst_pkg::ADDR_W-1:0]    ADDR,
    // data pins
    input  wire logic [sdram_burst_pkg::DQM_W-1:0]     DQM,
    input  wire logic [sdram_burst_pkg::DQ_W-1:0]      DQ_IN,
    output logic      [sdram_burst_pkg::DQ_W-1:0]      DQ_OUT,
    output logic      [sdram_burst_pkg::DQM_W-1:0]     DQ_OE,
    // status
    output logic      [sdram_burst_pkg::ADDR_W-1:0]    MODE_REG,
    output logic                                       MODE_UNSUPPORTED,
    output logic      [sdram_burst_pkg::NUM_BANKS-1:0] BANK_OPEN,
    output logic                                       BURST_ACTIVE,
    output logic                                       ACCESS_VALID,
    output logic                                       ACCESS_WRITE,
    output logic      [sdram_burst_pkg::COL_W-1:0]     ACCESS_COL,
    output logic      [sdram_burst_pkg::ADDR_W-1:0]    REFRESH_ROW,
    output logic                                       SELF_REFRESH
);

    localparam int CW = sdram_burst_pkg::COL_W;
    localparam int RK = sdram_burst_pkg::ROW_KEEP;
    localparam int BW = sdram_burst_pkg::BA_W;

    // ************************************************************
    // state
    // ************************************************************
    logic [sdram_burst_pkg::ADDR_W-1:0]    mode_ff;
    logic                                  mode_bad_ff;
    logic                                  self_ref_ff;
    logic [sdram_burst_pkg::ADDR_W-1:0]    refresh_row_ff;
    logic [sdram_burst_pkg::NUM_BANKS-1:0] bank_open_ff;
    logic [RK-1:0]                         row_ff [sdram_burst_pkg::NUM_BANKS];
    logic                                  burst_ff;
    logic [CW-1:0]                         start_ff;
    logic [CW-1:0]                         mask_ff;
    logic [CW-1:0]                         count_ff;
    logic                                  page_ff;
    logic                                  inter_ff;
    logic                                  wr_ff;
    logic                                  ap_ff;
    logic [BW-1:0]                         bank_ff;
    logic                                  rd_d1_ff;
    logic [sdram_burst_pkg::MEM_AW-1:0]    rd_addr_d1_ff;
    logic                                  rd_d2_ff;
    logic [sdram_burst_pkg::MEM_AW-1:0]    rd_addr_d2_ff;
    logic [sdram_burst_pkg::DQM_W-1:0]     dqm_d1_ff;
    logic [sdram_burst_pkg::DQM_W-1:0]     dq_oe_ff;
    logic                                  acc_valid_ff;
    logic                                  acc_write_ff;
    logic [CW-1:0]                         acc_col_ff;

    sdram_burst_pkg::cmd_t cmd;
    logic [2:0]                            pins;
    logic [2:0]                            len_code;
    logic                                  full_page;
    logic                                  lat_three;
    logic                                  interleave;
    logic [CW-1:0]                         mode_mask;
    logic [CW-1:0]                         new_mask;
    logic                                  new_page;
    logic                                  nxt_mode_bad;
    logic                                  issue_v;
    logic                                  issue_wr;
    logic                                  issue_last;
    logic                                  issue_ap;
    logic [BW-1:0]                         issue_bank;
    logic [CW-1:0]                         issue_col;
    logic [CW-1:0]                         offset;
    logic [sdram_burst_pkg::MEM_AW-1:0]    issue_addr;
    logic                                  rd_issue;
    logic                                  mem_re;
    logic [sdram_burst_pkg::MEM_AW-1:0]    mem_raddr;
    logic                                  ap_close;

    // ************************************************************
    // command decode
    // ************************************************************
    assign pins = {RAS_N, CAS_N, WE_N};

    always_comb begin
        cmd = sdram_burst_pkg::CMD_INHIBIT;
        if (self_ref_ff) begin
            cmd = sdram_burst_pkg::CMD_INHIBIT;
        end else if (CS_N) begin
            cmd = sdram_burst_pkg::CMD_INHIBIT;
        end else if (!CKE) begin
            if (pins == sdram_burst_pkg::PIN_REFRESH) begin
                cmd = sdram_burst_pkg::CMD_SELF_REF;
            end
        end else if (pins == sdram_burst_pkg::PIN_NOP) begin
            cmd = sdram_burst_pkg::CMD_NOP;
        end else if (pins == sdram_burst_pkg::PIN_ACTIVE) begin
            cmd = sdram_burst_pkg::CMD_ACTIVE;
        end else if (pins == sdram_burst_pkg::PIN_READ) begin
            cmd = sdram_burst_pkg::CMD_READ;
        end else if (pins == sdram_burst_pkg::PIN_WRITE) begin
            cmd = sdram_burst_pkg::CMD_WRITE;
        end else if (pins == sdram_burst_pkg::PIN_TERM) begin
            cmd = sdram_burst_pkg::CMD_TERM;
        end else if (pins == sdram_burst_pkg::PIN_PRECHG) begin
            cmd = sdram_burst_pkg::CMD_PRECHG;
        end else if (pins == sdram_burst_pkg::PIN_REFRESH) begin
            cmd = sdram_burst_pkg::CMD_AUTO_REF;
        end else begin
            cmd = sdram_burst_pkg::CMD_LOADMR;
        end
    end

    // ************************************************************
    // mode register fields
    // ************************************************************
    assign len_code = mode_ff[sdram_burst_pkg::LEN_MSB:sdram_burst_pkg::LEN_LSB];
    assign full_page = (len_code == sdram_burst_pkg::LEN_PAGE);
    assign lat_three = (mode_ff[sdram_burst_pkg::LAT_MSB:sdram_burst_pkg::LAT_LSB]
                        == sdram_burst_pkg::LAT_THREE);
    // page bursts always run sequential
    assign interleave = mode_ff[sdram_burst_pkg::TYPE_BIT] & ~full_page;

    always_comb begin
        if (len_code == sdram_burst_pkg::LEN_TWO) begin
            mode_mask = sdram_burst_pkg::MASK_TWO;
        end else if (len_code == sdram_burst_pkg::LEN_FOUR) begin
            mode_mask = sdram_burst_pkg::MASK_FOUR;
        end else if (len_code == sdram_burst_pkg::LEN_EIGHT) begin
            mode_mask = sdram_burst_pkg::MASK_EIGHT;
        end else if (full_page) begin
            mode_mask = sdram_burst_pkg::MASK_PAGE;
        end else begin
            mode_mask = sdram_burst_pkg::MASK_ONE;
        end
    end

    // single-column writes when the write-burst bit is set
    assign new_mask = (cmd == sdram_burst_pkg::CMD_WRITE
                       && mode_ff[sdram_burst_pkg::WBURST_BIT])
                      ? sdram_burst_pkg::MASK_ONE : mode_mask;
    assign new_page = full_page && (new_mask == sdram_burst_pkg::MASK_PAGE);

    always_comb begin
        nxt_mode_bad = 1'b0;
        if (!(len_code <= sdram_burst_pkg::LEN_EIGHT || full_page)) begin
            nxt_mode_bad = 1'b1;
        end
        if (mode_ff[sdram_burst_pkg::LAT_MSB:sdram_burst_pkg::LAT_LSB]
            != sdram_burst_pkg::LAT_TWO && !lat_three) begin
            nxt_mode_bad = 1'b1;
        end
        if (mode_ff[sdram_burst_pkg::OPM_MSB:sdram_burst_pkg::OPM_LSB]
            != sdram_burst_pkg::OPM_NORMAL) begin
            nxt_mode_bad = 1'b1;
        end
        if (full_page && mode_ff[sdram_burst_pkg::TYPE_BIT]) begin
            nxt_mode_bad = 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            mode_ff <= sdram_burst_pkg::MODE_RESET;
        end else if (cmd == sdram_burst_pkg::CMD_LOADMR) begin
            mode_ff <= ADDR;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            mode_bad_ff <= 1'b0;
        end else begin
            mode_bad_ff <= nxt_mode_bad;
        end
    end

    // ************************************************************
    // column issue: slot 0 straight from the command, rest from state
    // ************************************************************
    always_comb begin
        issue_v    = 1'b0;
        issue_wr   = 1'b0;
        issue_last = 1'b0;
        issue_ap   = 1'b0;
        issue_bank = BA;
        issue_col  = ADDR[CW-1:0];
        offset     = '0;
        if (cmd == sdram_burst_pkg::CMD_READ
            || cmd == sdram_burst_pkg::CMD_WRITE) begin
            issue_v    = 1'b1;
            issue_wr   = (cmd == sdram_burst_pkg::CMD_WRITE);
            issue_last = (new_mask == sdram_burst_pkg::MASK_ONE);
            // auto precharge has no meaning for page bursts
            issue_ap   = ADDR[sdram_burst_pkg::AUTOPRE_BIT] & ~new_page;
        end else if (burst_ff && cmd != sdram_burst_pkg::CMD_TERM) begin
            if (inter_ff) begin
                offset = start_ff ^ count_ff;
            end else begin
                offset = start_ff + count_ff;
            end
            // block bits fixed, offset wraps inside the block
            issue_col  = (start_ff & ~mask_ff) | (offset & mask_ff);
            issue_v    = 1'b1;
            issue_wr   = wr_ff;
            issue_bank = bank_ff;
            issue_last = ~page_ff && (count_ff == mask_ff);
            issue_ap   = ap_ff;
        end
    end

    assign issue_addr = {issue_bank, row_ff[issue_bank], issue_col};
    assign ap_close   = issue_v & issue_last & issue_ap;

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            burst_ff <= 1'b0;
            start_ff <= '0;
            mask_ff  <= '0;
            count_ff <= '0;
            page_ff  <= 1'b0;
            inter_ff <= 1'b0;
            wr_ff    <= 1'b0;
            ap_ff    <= 1'b0;
            bank_ff  <= '0;
        end else if (cmd == sdram_burst_pkg::CMD_READ
                     || cmd == sdram_burst_pkg::CMD_WRITE) begin
            // a new access cuts off whatever burst was running
            burst_ff <= (new_mask != sdram_burst_pkg::MASK_ONE);
            start_ff <= ADDR[CW-1:0];
            mask_ff  <= new_mask;
            count_ff <= sdram_burst_pkg::COL_STEP;
            page_ff  <= new_page;
            inter_ff <= interleave;
            wr_ff    <= (cmd == sdram_burst_pkg::CMD_WRITE);
            ap_ff    <= issue_ap;
            bank_ff  <= BA;
        end else if (cmd == sdram_burst_pkg::CMD_TERM) begin
            burst_ff <= 1'b0;
        end else if (burst_ff) begin
            if (issue_last) begin
                burst_ff <= 1'b0;
            end
            count_ff <= count_ff + sdram_burst_pkg::COL_STEP;
        end
    end

    // ************************************************************
    // bank rows
    // ************************************************************
    genvar b;
    generate
        for (b = 0; b < sdram_burst_pkg::NUM_BANKS; b = b + 1) begin : bank
            always_ff @(posedge CLK) begin
                if (SYS_RST) begin
                    bank_open_ff[b] <= 1'b0;
                    row_ff[b]       <= '0;
                end else if (cmd == sdram_burst_pkg::CMD_ACTIVE
                             && BA == BW'(b)) begin
                    bank_open_ff[b] <= 1'b1;
                    row_ff[b]       <= ADDR[RK-1:0];
                end else if (cmd == sdram_burst_pkg::CMD_PRECHG
                             && (ADDR[sdram_burst_pkg::AUTOPRE_BIT]
                                 || BA == BW'(b))) begin
                    bank_open_ff[b] <= 1'b0;
                end else if (ap_close && issue_bank == BW'(b)) begin
                    bank_open_ff[b] <= 1'b0;
                end
            end
        end
    endgenerate

    // ************************************************************
    // refresh
    // ************************************************************
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            refresh_row_ff <= '0;
        end else if (cmd == sdram_burst_pkg::CMD_AUTO_REF
                     || cmd == sdram_burst_pkg::CMD_SELF_REF) begin
            refresh_row_ff <= refresh_row_ff + sdram_burst_pkg::REF_STEP;
        end
    end

    // self refresh ends only when clock enable returns high
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            self_ref_ff <= 1'b0;
        end else if (cmd == sdram_burst_pkg::CMD_SELF_REF) begin
            self_ref_ff <= 1'b1;
        end else if (self_ref_ff && CKE) begin
            self_ref_ff <= 1'b0;
        end
    end

    // ************************************************************
    // data path
    // ************************************************************
    assign rd_issue = issue_v & ~issue_wr;
    // the store loads at edge n+m-1, so the word is sampled at edge n+m
    assign mem_re    = lat_three ? rd_d2_ff : rd_d1_ff;
    assign mem_raddr = lat_three ? rd_addr_d2_ff : rd_addr_d1_ff;

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            rd_d1_ff      <= 1'b0;
            rd_addr_d1_ff <= '0;
            rd_d2_ff      <= 1'b0;
            rd_addr_d2_ff <= '0;
            dqm_d1_ff     <= '1;
        end else begin
            rd_d1_ff      <= rd_issue;
            rd_addr_d1_ff <= issue_addr;
            rd_d2_ff      <= rd_d1_ff;
            rd_addr_d2_ff <= rd_addr_d1_ff;
            dqm_d1_ff     <= DQM;
        end
    end

    // drive starts at the edge that loads the word, one before it is sampled
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            dq_oe_ff <= '0;
        end else begin
            dq_oe_ff <= {sdram_burst_pkg::DQM_W{mem_re}} & ~dqm_d1_ff;
        end
    end

    sdram_cell_store store (
        .clk   (CLK),
        .we    (issue_v & issue_wr),
        .be    (~DQM),
        .waddr (issue_addr),
        .wdata (DQ_IN),
        .re    (mem_re),
        .raddr (mem_raddr),
        .rdata (DQ_OUT)
    );

    // ************************************************************
    // status
    // ************************************************************
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            acc_valid_ff <= 1'b0;
            acc_write_ff <= 1'b0;
            acc_col_ff   <= '0;
        end else begin
            acc_valid_ff <= issue_v;
            acc_write_ff <= issue_wr;
            acc_col_ff   <= issue_col;
        end
    end

    assign DQ_OE            = dq_oe_ff;
    assign MODE_REG         = mode_ff;
    assign MODE_UNSUPPORTED = mode_bad_ff;
    assign BANK_OPEN        = bank_open_ff;
    assign BURST_ACTIVE     = burst_ff;
    assign ACCESS_VALID     = acc_valid_ff;
    assign ACCESS_WRITE     = acc_write_ff;
    assign ACCESS_COL       = acc_col_ff;
    assign REFRESH_ROW      = refresh_row_ff;
    assign SELF_REFRESH     = self_ref_ff;

endmodule

// ==== core/sdram_burst_pkg.sv ====
// shared constants and types for the sdram command and burst logic
package sdram_burst_pkg;

    // ************************************************************
    // widths of the command bus and of the data store
    // ************************************************************
    localparam int ADDR_W    = 12;
    localparam int BA_W      = 2;
    localparam int NUM_BANKS = 4;
    localparam int COL_W     = 8;
    localparam int DQ_W      = 16;
    localparam int DQM_W     = 2;
    localparam int BYTE_W    = 8;
    // low row bits kept by the store; higher rows alias onto these
    localparam int ROW_KEEP  = 2;
    localparam int MEM_AW    = BA_W + ROW_KEEP + COL_W;

    // ************************************************************
    // mode register field positions
    // ************************************************************
    localparam int LEN_LSB    = 0;
    localparam int LEN_MSB    = 2;
    localparam int TYPE_BIT   = 3;
    localparam int LAT_LSB    = 4;
    localparam int LAT_MSB    = 6;
    localparam int OPM_LSB    = 7;
    localparam int OPM_MSB    = 8;
    localparam int WBURST_BIT = 9;
    localparam int AUTOPRE_BIT = 10;

    // ************************************************************
    // mode register codes and reset value
    // ************************************************************
    localparam logic [2:0] LEN_ONE    = 3'h0;
    localparam logic [2:0] LEN_TWO    = 3'h1;
    localparam logic [2:0] LEN_FOUR   = 3'h2;
    localparam logic [2:0] LEN_EIGHT  = 3'h3;
    localparam logic [2:0] LEN_PAGE   = 3'h7;
    localparam logic [2:0] LAT_TWO    = 3'h2;
    localparam logic [2:0] LAT_THREE  = 3'h3;
    localparam logic [1:0] OPM_NORMAL = 2'h0;
    localparam logic [ADDR_W-1:0] MODE_RESET = 12'h020;

    // column masks: low bits that wrap inside the burst block
    localparam logic [COL_W-1:0] MASK_ONE   = 8'h00;
    localparam logic [COL_W-1:0] MASK_TWO   = 8'h01;
    localparam logic [COL_W-1:0] MASK_FOUR  = 8'h03;
    localparam logic [COL_W-1:0] MASK_EIGHT = 8'h07;
    localparam logic [COL_W-1:0] MASK_PAGE  = 8'hFF;
    localparam logic [COL_W-1:0] COL_STEP   = 8'h01;
    localparam logic [ADDR_W-1:0] REF_STEP  = 12'h001;

    // ************************************************************
    // strobe codes {ras_n, cas_n, we_n} with select low
    // ************************************************************
    localparam logic [2:0] PIN_NOP     = 3'h7;
    localparam logic [2:0] PIN_ACTIVE  = 3'h3;
    localparam logic [2:0] PIN_READ    = 3'h5;
    localparam logic [2:0] PIN_WRITE   = 3'h4;
    localparam logic [2:0] PIN_TERM    = 3'h6;
    localparam logic [2:0] PIN_PRECHG  = 3'h2;
    localparam logic [2:0] PIN_REFRESH = 3'h1;
    localparam logic [2:0] PIN_LOADMR  = 3'h0;

    typedef enum logic [9:0] {
        CMD_INHIBIT  = 10'b00_0000_0001,
        CMD_NOP      = 10'b00_0000_0010,
        CMD_ACTIVE   = 10'b00_0000_0100,
        CMD_READ     = 10'b00_0000_1000,
        CMD_WRITE    = 10'b00_0001_0000,
        CMD_TERM     = 10'b00_0010_0000,
        CMD_PRECHG   = 10'b00_0100_0000,
        CMD_AUTO_REF = 10'b00_1000_0000,
        CMD_SELF_REF = 10'b01_0000_0000,
        CMD_LOADMR   = 10'b10_0000_0000
    } cmd_t;

endpackage

// ==== core/sdram_cell_store.sv ====
// column data store with byte-lane writes and a registered read port
`timescale 1ns/1ps
module sdram_cell_store (
    // clock
    input  wire logic                                   clk,
    // write port
    input  wire logic                                   we,
    input  wire logic [sdram_burst_pkg::DQM_W-1:0]      be,
    input  wire logic [sdram_burst_pkg::MEM_AW-1:0]     waddr,
    input  wire logic [sdram_burst_pkg::DQ_W-1:0]       wdata,
    // read port
    input  wire logic                                   re,
    input  wire logic [sdram_burst_pkg::MEM_AW-1:0]     raddr,
    output logic      [sdram_burst_pkg::DQ_W-1:0]       rdata
);

    localparam int DEPTH = 1 << sdram_burst_pkg::MEM_AW;
    localparam int BW    = sdram_burst_pkg::BYTE_W;

    // ************************************************************
    // one array per byte lane
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < sdram_burst_pkg::DQM_W; g = g + 1) begin : lane
            logic [BW-1:0] cells [DEPTH];

            always_ff @(posedge clk) begin
                if (we && be[g]) begin
                    cells[waddr] <= wdata[g*BW +: BW];
                end
            end

            // data holds between reads so the pins stay steady
            always_ff @(posedge clk) begin
                if (re) begin
                    rdata[g*BW +: BW] <= cells[raddr];
                end
            end
        end
    endgenerate

endmodule

// ==== bench/sdram_burst_chk.sv ====
// port assertions for the sdram command and burst logic
`timescale 1ns/1ps
module sdram_burst_chk (
    // clock, reset and command bus
    input logic        CLK, SYS_RST, CKE, CS_N, RAS_N, CAS_N, WE_N,
    input logic [1:0]  BA, DQM,
    input logic [11:0] ADDR,
    // data enables and status
    input logic [1:0]  DQ_OE,
    input logic [11:0] MODE_REG, REFRESH_ROW,
    input logic [3:0]  BANK_OPEN,
    input logic        MODE_UNSUPPORTED, ACCESS_VALID, SELF_REFRESH,
    input logic [7:0]  ACCESS_COL
);
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    // a command other than self refresh entry is taken only when selected, enabled and awake
    logic       s;
    logic [2:0] p;
    assign s = !CS_N && CKE && !SELF_REFRESH;
    assign p = {RAS_N, CAS_N, WE_N};
    mode_load_a: assert property (s && p == 3'h0
        |=> MODE_REG == $past(ADDR)) else $error("mode not loaded");
    deselect_hold_a: assert property (CS_N
        |=> $stable(MODE_REG)) else $error("deselect changed mode");
    row_open_a: assert property (s && p == 3'h3
        |=> BANK_OPEN[$past(BA)]) else $error("bank not opened");
    close_all_a: assert property (s && p == 3'h2 && ADDR[10]
        |=> BANK_OPEN == 4'h0) else $error("banks left open");
    first_slot_a: assert property (s && p[2:1] == 2'h2
        |=> ACCESS_VALID && ACCESS_COL == $past(ADDR[7:0]))
        else $error("first slot column wrong");
    read_drive_a: assert property (s && p == 3'h5
        && MODE_REG[6:4] == 3'h2
        |=> ##1 DQ_OE == ~$past(DQM, 2)) else $error("read drive wrong");
    refresh_step_a: assert property (s && p == 3'h1
        |=> REFRESH_ROW == $past(REFRESH_ROW) + 12'h001)
        else $error("refresh row not stepped");
    self_entry_a: assert property (!CS_N && !CKE && p == 3'h1
        |=> SELF_REFRESH) else $error("self refresh missed");
    bad_mode_a: assert property (MODE_REG[8:7] != 2'h0
        |=> MODE_UNSUPPORTED) else $error("reserved mode not flagged");
endmodule

// ==== bench/sdram_ctrl_model.sv ====
// command bus driver standing in for the memory controller
`timescale 1ns/1ps
module sdram_ctrl_model (
    input wire logic    CLK,
    output logic        CKE, CS_N, RAS_N, CAS_N, WE_N,
    output logic [1:0]  BA, DQM,
    output logic [11:0] ADDR,
    output logic [15:0] DQ
);
    initial {CKE, CS_N, RAS_N, CAS_N, WE_N, BA, DQM, ADDR, DQ} = '1;
    // one command a cycle, changed at the falling edge
    task automatic send(input logic [4:0] c, input logic [31:0] r);
        @(negedge CLK);
        {CKE, CS_N, RAS_N, CAS_N, WE_N} <= c;
        {BA, DQM, ADDR, DQ} <= r;
    endtask
endmodule

// ==== bench/testbench.sv ====
// self-checking bench for the sdram command and burst logic
`timescale 1ns/1ps
`define CHECK(g, w) begin samples_checked++; if ((g) !== (w)) begin \
    miscompares++; $display("MISMATCH %0t got %h want %h", $time, g, w); end end
module testbench;
    localparam logic [11:0] MODES [8] = '{12'h020, 12'h028, 12'h021,
        12'h02A, 12'h023, 12'h03B, 12'h222, 12'h027};
    logic        CLK, SYS_RST, CKE, CS_N, RAS_N, CAS_N, WE_N, SELF_REFRESH;
    logic        MODE_UNSUPPORTED, BURST_ACTIVE, ACCESS_VALID, ACCESS_WRITE;
    logic [1:0]  BA, DQM, DQ_OE, bk, rw, dq_prev;
    logic [12:0] d, pend [2] = '{default: '0};
    logic [3:0]  BANK_OPEN;
    logic [7:0]  ACCESS_COL, st, mk, ev;
    logic [9:0]  pe, got, exp_q[$];
    logic [11:0] ADDR, MODE_REG, REFRESH_ROW, m;
    logic [15:0] DQ_IN, DQ_OUT, rnd;
    logic [15:0] shadow [4096];
    int          miscompares, samples_checked, cycles, n;
    sdram_ctrl_model i_sdram_ctrl_model (.CLK, .CKE, .CS_N, .RAS_N, .CAS_N,
        .WE_N, .BA, .DQM, .ADDR, .DQ(DQ_IN));
    sdram_burst_core i_sdram_burst_core (.CLK, .SYS_RST, .CKE, .CS_N, .RAS_N,
        .CAS_N, .WE_N, .BA, .ADDR, .DQM, .DQ_IN, .DQ_OUT, .DQ_OE, .MODE_REG,
        .MODE_UNSUPPORTED, .BANK_OPEN, .BURST_ACTIVE, .ACCESS_VALID,
        .ACCESS_WRITE, .ACCESS_COL, .REFRESH_ROW, .SELF_REFRESH);
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // filler: random deselects with junk strobes, or no-ops
    task automatic idle(input int k);
        repeat (k) begin
            rnd = lfsr(rnd);
            i_sdram_ctrl_model.send({1'b1, rnd[2], rnd[2] ? rnd[5:3] : 3'h7},
                {rnd, rnd});
        end
    endtask
    task automatic cmd(input logic ck, input logic [2:0] p,
                       input logic [11:0] a);
        rnd = lfsr(rnd);
        i_sdram_ctrl_model.send({ck, 1'b0, p}, {bk, rnd[3:2], a, rnd});
    endtask
    // expected columns are queued before the command goes out
    task automatic burst(input logic [2:0] p, input int k);
        for (int i = 0; i < k; i++) begin
            ev = m[3] ? st ^ i[7:0] : st + i[7:0];
            exp_q.push_back({m[2:0] == 3'h7 && k > 1 || i < k - 1,
                p == 3'h4, (st & ~mk) | (ev & mk)});
        end
        cmd(1'b1, p, {4'h0, st});
        if (m[2:0] == 3'h7) begin
            idle(k - 1);
            cmd(1'b1, 3'h6, 12'h000);
        end
        idle(k + 5);
    endtask
    task automatic complete_run();
        if (exp_q.size() != 0) miscompares++;
        $display("checked %0d mismatched %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            complete_run();
        end
    end
    // read words come m-1 cycles after their slot; lanes follow old masks
    always @(negedge CLK) begin
        d = m[6:4] == 3'h3 ? pend[1] : pend[0];
        if (SYS_RST === 1'b0)
            `CHECK(DQ_OE, d[12] ? ~dq_prev : 2'h0)
        for (int b = 0; b < 2; b++)
            if (d[12] && !dq_prev[b])
                `CHECK(DQ_OUT[b*8 +: 8], shadow[d[11:0]][b*8 +: 8])
        if (ACCESS_VALID === 1'b1) begin
            got = {BURST_ACTIVE, ACCESS_WRITE, ACCESS_COL};
            pe = exp_q.size() ? exp_q.pop_front() : ~got;
            `CHECK(got, pe)
            for (int b = 0; b < 2; b++)
                if (pe[8] && !DQM[b])
                    shadow[{bk, rw, pe[7:0]}][b*8 +: 8] = DQ_IN[b*8 +: 8];
        end
        pend[1] = pend[0];
        pend[0] = {ACCESS_VALID === 1'b1 && !pe[8], bk, rw, pe[7:0]};
        dq_prev = DQM;
    end
    initial begin
        SYS_RST = 1'b1;
        rnd = 16'h005F;
        repeat (3) @(posedge CLK);
        @(negedge CLK) SYS_RST <= 1'b0;
        idle(2);
        foreach (MODES[j]) begin
            m = MODES[j];
            n = m[2:0] == 3'h7 ? 5 : 1 << m[2:0];
            mk = m[2:0] == 3'h7 ? 8'hFF : 8'(n - 1);
            bk = rnd[1:0];
            cmd(1'b1, 3'h0, m);
            idle(2);
            rw = rnd[1:0];
            cmd(1'b1, 3'h3, rnd[11:0]);
            idle(1);
            st = m[2:0] == 3'h7 ? 8'hFE : rnd[7:0];
            burst(3'h4, m[9] ? 1 : n);
            burst(3'h5, n);
            cmd(1'b1, 3'h2, 12'h400);
            idle(2);
        end
        cmd(1'b1, 3'h1, rnd[11:0]);
        idle(2);
        cmd(1'b0, 3'h1, rnd[11:0]);
        repeat (3) i_sdram_ctrl_model.send({1'b0, rnd[3:0]}, {rnd, rnd});
        idle(4);
        cmd(1'b1, 3'h0, 12'h1A2);
        idle(3);
        cmd(1'b1, 3'h0, 12'h020);
        idle(4);
        complete_run();
    end
endmodule
bind sdram_burst_core sdram_burst_chk i_sdram_burst_chk (.CLK, .SYS_RST,
    .CKE, .CS_N, .RAS_N, .CAS_N, .WE_N, .BA, .DQM, .ADDR, .DQ_OE, .MODE_REG,
    .REFRESH_ROW, .BANK_OPEN, .MODE_UNSUPPORTED, .ACCESS_VALID,
    .SELF_REFRESH, .ACCESS_COL);
